// ---- host_port_properties.sv ----
/* Port checker for radio_host_port.
   Assumes a bind onto the top module and one clock domain. */
`timescale 1ns/10ps
module host_port_properties #(
    parameter int REMOTE_W = 4
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic serial_out_o,
    input wire logic permit_send_n_i,
    input wire logic accept_ready_n_o,
    input wire logic rx_valid_o,
    input wire logic activity_flag_o,
    input wire logic is_base_i,
    input wire logic hop_locked_i,
    input wire logic [REMOTE_W-1:0] remotes_connected_i,
    input wire logic carrier_lock_n_o,
    input wire logic ss_n_oe_o,
    input wire logic mosi_oe_o,
    input wire logic miso_oe_o,
    input wire logic sclk_oe_o,
    input wire logic general_io_four_oe_o,
    input wire logic general_io_four_pullup_o
);
    // ==================================================
    // Checks; the synchroniser delay sets the four-cycle permit window
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_OE_GROUP: assert property (
        ss_n_oe_o == mosi_oe_o && sclk_oe_o == mosi_oe_o)
        else $error("master pin enables disagree");
    AST_MISO_OE: assert property (miso_oe_o |-> !mosi_oe_o)
        else $error("miso and mosi both driven");
    AST_TX_START: assert property (
        tx_valid_i && tx_ready_o |=> !serial_out_o && !tx_ready_o)
        else $error("no start bit after take");
    AST_PERMIT: assert property (permit_send_n_i [*4] |-> !tx_ready_o)
        else $error("ready to send while blocked");
    AST_READY: assert property (rx_valid_o |-> accept_ready_n_o)
        else $error("ready while holding byte full");
    AST_ACT: assert property (tx_valid_i && tx_ready_o |=> activity_flag_o [*8])
        else $error("activity low during frame");
    AST_LOCK_REMOTE: assert property (
        !$past(is_base_i) |-> carrier_lock_n_o == !$past(hop_locked_i))
        else $error("remote lock wrong");
    AST_LOCK_BASE: assert property (
        $past(is_base_i) |-> carrier_lock_n_o == ($past(remotes_connected_i) == '0))
        else $error("base lock wrong");
    AST_PULLUP: assert property (general_io_four_pullup_o |-> !general_io_four_oe_o)
        else $error("pull-up on an output");
endmodule

// ---- host_side_model.sv ----
/* Host model: serial sender and receiver plus an SPI slave.
   Assumes the port runs 16 clocks per serial bit. */
`timescale 1ns/10ps
module host_side_model #(
    parameter int CPB = 16
) (
    input wire logic clock_i,
    input wire logic serial_out_o,
    input wire logic accept_ready_n_o,
    output logic serial_in_i,
    input wire logic ss_n_o,
    input wire logic sclk_o,
    input wire logic mosi_o,
    output logic miso_i,
    output logic [7:0] got_byte,
    output logic [7:0] spi_got
);
    // ==================================================
    // Serial side; the line idles high
    logic [7:0] miso_sh = 8'h5a;
    initial serial_in_i = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (accept_ready_n_o) @(posedge clock_i);
        for (int i = 0; i < 10; i++) begin
            serial_in_i <= f[i];
            repeat (CPB) @(posedge clock_i);
        end
    endtask
    // Mid-bit sampling of the port's output, LSB first
    always begin
        @(negedge serial_out_o);
        repeat (CPB / 2) @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            repeat (CPB) @(posedge clock_i);
            got_byte[i] = serial_out_o;
        end
        repeat (CPB) @(posedge clock_i);
    end
    // SPI slave, mode 0; a deselected line shows the inverse, never a stale bit
    assign miso_i = ss_n_o ? ~miso_sh[7] : miso_sh[7];
    always @(negedge sclk_o) if (!ss_n_o) miso_sh = {miso_sh[6:0], miso_sh[7]};
    always @(posedge sclk_o) if (!ss_n_o) spi_got = {spi_got[6:0], mosi_o};
endmodule

// ---- radio_host_port.sv ----
/*
 * Host-facing port of the radio module: serial transmitter and receiver
 * with flow control, SPI master/slave pin handling, activity and carrier
 * lock outputs, and two configurable general I/O pins.
 * Assumes pins are asynchronous to clock_i; user-side ports are synchronous.
 */
`timescale 1ns/10ps
module radio_host_port #(
    parameter int CLKS_PER_BIT = radio_port_pkg::BIT_CYCLES,
    parameter int SPI_HALF = radio_port_pkg::SPI_HALF_CYCLES,
    parameter int REMOTE_W = 4
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Serial lines and flow control
    input wire logic serial_in_i,
    output logic serial_out_o,
    input wire logic permit_send_n_i,
    output logic accept_ready_n_o,
    // User side of the serial and SPI data
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_taken_i,
    input wire logic [7:0] spi_tx_data_i,
    input wire logic spi_start_i,
    // SPI pins
    input wire logic role_master_i,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    // Status
    input wire logic is_base_i,
    input wire logic hop_locked_i,
    input wire logic [REMOTE_W-1:0] remotes_connected_i,
    output logic activity_flag_o,
    output logic carrier_lock_n_o,
    // General I/O four and five, bit 0 is four
    input wire logic [1:0] gpio_dir_out_i,
    input wire logic [1:0] gpio_pullup_i,
    input wire logic [1:0] gpio_power_on_i,
    input wire logic [1:0] gpio_write_i,
    input wire logic [1:0] gpio_level_i,
    input wire logic general_io_four_i,
    input wire logic general_io_five_i,
    output logic general_io_four_o,
    output logic general_io_four_oe_o,
    output logic general_io_four_pullup_o,
    output logic general_io_five_o,
    output logic general_io_five_oe_o,
    output logic general_io_five_pullup_o,
    output logic [1:0] gpio_in_o
);

    localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);   // Full bit count end
    localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2);  // Mid-start sample point
    localparam logic [15:0] SPI_LAST = 16'(SPI_HALF - 1);       // SPI half period end

    // ============
    // Pin synchronisers
    // ============
    logic [7:0] pins;  // Synchronised pin levels
    logic serial_s, permit_n_s, ss_n_s, mosi_s, miso_s, sclk_s;
    sync_bits #(.WIDTH(8)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i({general_io_five_i, general_io_four_i, sclk_i, miso_i, mosi_i, ss_n_i,
                  permit_send_n_i, serial_in_i}),
        .sync_o(pins)
    );
    assign serial_s = pins[0];
    assign permit_n_s = pins[1];
    assign ss_n_s = pins[2];
    assign mosi_s = pins[3];
    assign miso_s = pins[4];
    assign sclk_s = pins[5];

    // ============
    // Serial transmitter
    // ============
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    tx_state_t tx_state, next_tx_state;
    logic [9:0] tx_frame, next_tx_frame;   // Start, data, stop; sent from bit 0
    logic [3:0] tx_bit, next_tx_bit;       // Bit of the frame on the line
    logic [15:0] tx_baud, next_tx_baud;    // Cycles into the current bit
    logic next_serial_out, next_tx_ready;

    // New characters start only while permitted; one in flight always ends
    always_comb begin
        next_tx_state = tx_state;
        next_tx_frame = tx_frame;
        next_tx_bit = tx_bit;
        next_tx_baud = tx_baud;
        unique case (tx_state)
            TX_IDLE: begin
                if (tx_valid_i && tx_ready_o) begin
                    next_tx_frame = {1'b1, tx_data_i, 1'b0};
                    next_tx_state = TX_SEND;
                    next_tx_bit = 4'h0;
                    next_tx_baud = 16'h0000;
                end
            end
            TX_SEND: begin
                if (tx_baud == BIT_LAST) begin
                    next_tx_baud = 16'h0000;
                    next_tx_frame = {1'b1, tx_frame[9:1]};
                    next_tx_bit = tx_bit + 4'h1;
                    if (tx_bit == radio_port_pkg::STOP_BIT_INDEX) begin
                        next_tx_state = TX_IDLE;
                    end
                end else begin
                    next_tx_baud = tx_baud + 16'h0001;
                end
            end
        endcase
        next_serial_out = (next_tx_state == TX_SEND) ? next_tx_frame[0] :
                          radio_port_pkg::LINE_IDLE;
        next_tx_ready = (next_tx_state == TX_IDLE) && !permit_n_s;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state <= TX_IDLE;
            tx_frame <= 10'h3ff;
            tx_bit <= 4'h0;
            tx_baud <= 16'h0000;
            serial_out_o <= radio_port_pkg::LINE_IDLE;
            tx_ready_o <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_frame <= next_tx_frame;
            tx_bit <= next_tx_bit;
            tx_baud <= next_tx_baud;
            serial_out_o <= next_serial_out;
            tx_ready_o <= next_tx_ready;
        end
    end

    // ============
    // Serial receiver
    // ============
    typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;
    rx_state_t rx_state, next_rx_state;
    logic [7:0] rx_shift, next_rx_shift;   // Bits gathered LSB first
    logic [3:0] rx_bit, next_rx_bit;       // 0 start, 1..8 data, 9 stop
    logic [15:0] rx_baud, next_rx_baud;
    logic uart_done;                       // Good stop bit seen this cycle

    // Start bit is rechecked at mid-bit so a line glitch is dropped
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_bit = rx_bit;
        next_rx_baud = rx_baud;
        uart_done = 1'b0;
        unique case (rx_state)
            RX_IDLE: begin
                if (!serial_s) begin
                    next_rx_state = RX_RUN;
                    next_rx_bit = 4'h0;
                    next_rx_baud = 16'h0000;
                end
            end
            RX_RUN: begin
                if (rx_baud == ((rx_bit == 4'h0) ? HALF_LAST : BIT_LAST)) begin
                    next_rx_baud = 16'h0000;
                    next_rx_bit = rx_bit + 4'h1;
                    if (rx_bit == 4'h0) begin
                        if (serial_s) begin
                            next_rx_state = RX_IDLE;  // False start
                        end
                    end else if (rx_bit == radio_port_pkg::STOP_BIT_INDEX) begin
                        next_rx_state = RX_IDLE;
                        uart_done = serial_s;  // Framing errors are dropped
                    end else begin
                        next_rx_shift = {serial_s, rx_shift[7:1]};
                    end
                end else begin
                    next_rx_baud = rx_baud + 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state <= RX_IDLE;
            rx_shift <= 8'h00;
            rx_bit <= 4'h0;
            rx_baud <= 16'h0000;
        end else begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_bit <= next_rx_bit;
            rx_baud <= next_rx_baud;
        end
    end

    // ============
    // SPI engine, mode 0, MSB first
    // ============
    typedef enum logic [1:0] {SPI_IDLE, SPI_MASTER, SPI_SLAVE} spi_state_t;
    spi_state_t spi_state, next_spi_state;
    logic [7:0] spi_tx, next_spi_tx;       // Outgoing byte, MSB on the pin
    logic [7:0] spi_rx, next_spi_rx;       // Incoming byte
    logic [3:0] spi_cnt, next_spi_cnt;     // Bits sampled so far
    logic [15:0] spi_div, next_spi_div;    // Half period counter
    logic master, next_master;             // Role, frozen during a transfer
    logic slave, next_slave;
    logic next_sclk_out, next_ss_out, sclk_prev, spi_done;

    // Role is latched only while idle so pin directions never flip mid-byte
    always_comb begin
        next_spi_state = spi_state;
        next_spi_tx = spi_tx;
        next_spi_rx = spi_rx;
        next_spi_cnt = spi_cnt;
        next_spi_div = spi_div;
        next_master = master;
        next_slave = slave;
        next_sclk_out = sclk_o;
        next_ss_out = ss_n_o;
        spi_done = 1'b0;
        unique case (spi_state)
            SPI_IDLE: begin
                next_master = role_master_i;
                next_slave = !role_master_i;
                next_spi_cnt = 4'h0;
                next_spi_div = 16'h0000;
                if (master && spi_start_i && !rx_valid_o) begin
                    next_spi_state = SPI_MASTER;
                    next_spi_tx = spi_tx_data_i;
                    next_ss_out = 1'b0;
                end else if (slave && !ss_n_s) begin
                    next_spi_state = SPI_SLAVE;
                    next_spi_tx = spi_tx_data_i;
                end
            end
            SPI_MASTER: begin
                if (spi_div == SPI_LAST) begin
                    next_spi_div = 16'h0000;
                    next_sclk_out = !sclk_o;
                    if (!sclk_o) begin
                        next_spi_rx = {spi_rx[6:0], miso_s};
                        next_spi_cnt = spi_cnt + 4'h1;
                    end else if (spi_cnt == radio_port_pkg::SPI_BYTE_BITS) begin
                        next_spi_state = SPI_IDLE;
                        next_ss_out = 1'b1;
                        spi_done = 1'b1;
                    end else begin
                        next_spi_tx = {spi_tx[6:0], 1'b0};
                    end
                end else begin
                    next_spi_div = spi_div + 16'h0001;
                end
            end
            SPI_SLAVE: begin
                if (ss_n_s) begin
                    next_spi_state = SPI_IDLE;  // Deselect aborts a partial byte
                end else if (sclk_s && !sclk_prev) begin
                    next_spi_rx = {spi_rx[6:0], mosi_s};
                    next_spi_cnt = spi_cnt + 4'h1;
                    if (spi_cnt == radio_port_pkg::SPI_LAST_BIT) begin
                        spi_done = 1'b1;
                        next_spi_cnt = 4'h0;
                    end
                end else if (!sclk_s && sclk_prev) begin
                    next_spi_tx = (spi_cnt == 4'h0) ? spi_tx_data_i :
                                  {spi_tx[6:0], 1'b0};
                end
            end
            default: begin
                next_spi_state = SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_state <= SPI_IDLE;
            spi_tx <= 8'h00;
            spi_rx <= 8'h00;
            spi_cnt <= 4'h0;
            spi_div <= 16'h0000;
            master <= 1'b0;
            slave <= 1'b0;
            sclk_o <= 1'b0;
            ss_n_o <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            spi_state <= next_spi_state;
            spi_tx <= next_spi_tx;
            spi_rx <= next_spi_rx;
            spi_cnt <= next_spi_cnt;
            spi_div <= next_spi_div;
            master <= next_master;
            slave <= next_slave;
            sclk_o <= next_sclk_out;
            ss_n_o <= next_ss_out;
            sclk_prev <= sclk_s;
        end
    end

    // Pin directions follow the latched role
    assign ss_n_oe_o = master;
    assign mosi_oe_o = master;
    assign sclk_oe_o = master;
    assign miso_oe_o = slave;
    assign mosi_o = spi_tx[7];
    assign miso_o = spi_tx[7];

    // ============
    // Receive holding byte, flow control and status
    // ============
    logic [7:0] next_rx_data;
    logic next_rx_valid, next_ready_n, next_activity, next_lock_n;

    // A byte arriving as the user takes the last one wins over the clear
    always_comb begin
        next_rx_data = uart_done ? rx_shift : (spi_done ? next_spi_rx : rx_data_o);
        next_rx_valid = (rx_valid_o && !rx_taken_i) || uart_done || spi_done;
        next_ready_n = next_rx_valid;
        next_activity = (next_tx_state != TX_IDLE) || (next_rx_state != RX_IDLE) ||
                        (next_spi_state != SPI_IDLE);
        if (is_base_i) begin
            next_lock_n = (remotes_connected_i == '0);
        end else begin
            next_lock_n = !hop_locked_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
            accept_ready_n_o <= radio_port_pkg::READY_N_RESET;
            activity_flag_o <= 1'b0;
            carrier_lock_n_o <= radio_port_pkg::LOCK_N_RESET;
        end else begin
            rx_data_o <= next_rx_data;
            rx_valid_o <= next_rx_valid;
            accept_ready_n_o <= next_ready_n;
            activity_flag_o <= next_activity;
            carrier_lock_n_o <= next_lock_n;
        end
    end

    // ============
    // General I/O four and five
    // ============
    logic [1:0] io_out, io_oe, io_pull;
    logic powered;  // Set on the first edge after reset release

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            powered <= 1'b0;
        end else begin
            powered <= 1'b1;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_io
        logic next_out, next_oe, next_pull;
        // Power-on level is taken after release, never inside the reset
        always_comb begin
            next_out = io_out[g];
            if (!powered) begin
                next_out = gpio_power_on_i[g];
            end else if (gpio_write_i[g]) begin
                next_out = gpio_level_i[g];
            end
            next_oe = gpio_dir_out_i[g];
            next_pull = !gpio_dir_out_i[g] && gpio_pullup_i[g];
        end
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                io_out[g] <= 1'b0;
                io_oe[g] <= 1'b0;
                io_pull[g] <= 1'b0;
                gpio_in_o[g] <= 1'b1;
            end else begin
                io_out[g] <= next_out;
                io_oe[g] <= next_oe;
                io_pull[g] <= next_pull;
                gpio_in_o[g] <= pins[6 + g];
            end
        end
    end

    assign general_io_four_o = io_out[0];
    assign general_io_four_oe_o = io_oe[0];
    assign general_io_four_pullup_o = io_pull[0];
    assign general_io_five_o = io_out[1];
    assign general_io_five_oe_o = io_oe[1];
    assign general_io_five_pullup_o = io_pull[1];

endmodule

// ---- radio_host_port_test.sv ----
/* Self-checking bench for radio_host_port.
   Assumes host_side_model and the bound checker; short counts for speed. */
`timescale 1ns/10ps
module radio_host_port_test;
    // ==================================================
    // Stimulus and wires
    logic clock_i = 1'b0, rst_n_i = 1'b0, permit_send_n_i = 1'b0, tx_valid_i = 1'b0;
    logic rx_taken_i = 1'b0, spi_start_i = 1'b0, role_master_i = 1'b1;
    logic is_base_i = 1'b0, hop_locked_i = 1'b0;
    logic [3:0] remotes_connected_i = 4'h0;
    logic [7:0] tx_data_i = 8'h00, spi_tx_data_i = 8'h96, rx_data_o, got_byte, spi_got;
    logic [1:0] gpio_dir_out_i = 2'h3, gpio_pullup_i = 2'h0, gpio_power_on_i = 2'h2;
    logic [1:0] gpio_write_i = 2'h0, gpio_level_i = 2'h0, gpio_in_o;
    logic serial_in_i, miso_i, serial_out_o, accept_ready_n_o, tx_ready_o, rx_valid_o;
    logic ss_n_o, ss_n_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, sclk_o, sclk_oe_o;
    logic activity_flag_o, carrier_lock_n_o, general_io_four_o, general_io_four_oe_o;
    logic general_io_four_pullup_o, general_io_five_o, general_io_five_oe_o;
    logic general_io_five_pullup_o;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    // Pin levels resolved from every driver; undriven pins rest at their pull
    wire logic ss_n_i = ss_n_oe_o ? ss_n_o : 1'b1;
    wire logic mosi_i = mosi_oe_o ? mosi_o : 1'b0;
    wire logic sclk_i = sclk_oe_o ? sclk_o : 1'b0;
    wire logic general_io_four_i = general_io_four_oe_o ? general_io_four_o :
        general_io_four_pullup_o;
    wire logic general_io_five_i = general_io_five_oe_o ? general_io_five_o :
        general_io_five_pullup_o;
    radio_host_port #(.CLKS_PER_BIT(16), .SPI_HALF(4)) i_dut (.*);
    host_side_model #(.CPB(16)) i_host (.*);
    always #2.5 clock_i = ~clock_i;
    // ==================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic send_tx(input logic [7:0] b);
        tx_data_i <= b;
        tx_valid_i <= 1'b1;
        @(posedge clock_i);
        while (tx_ready_o !== 1'b1) @(posedge clock_i);
        tx_valid_i <= 1'b0;
    endtask
    task automatic take_rx;
        rx_taken_i <= 1'b1;
        @(posedge clock_i);
        rx_taken_i <= 1'b0;
        @(posedge clock_i);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_tx; // A block in mid-frame lets the frame finish
        send_tx(8'ha5);
        repeat (40) @(posedge clock_i);
        permit_send_n_i <= 1'b1;
        repeat (160) @(posedge clock_i);
        chk(got_byte, 8'ha5);
        chk({7'h0, tx_ready_o}, 8'h00);
        tx_data_i <= 8'hc3;
        tx_valid_i <= 1'b1;
        repeat (40) @(posedge clock_i);
        chk({7'h0, serial_out_o}, 8'h01);
        permit_send_n_i <= 1'b0;
        send_tx(8'hc3);
        repeat (180) @(posedge clock_i);
        chk(got_byte, 8'hc3);
    endtask
    task automatic t_rx;
        i_host.send_byte(8'h3c);
        chk(rx_data_o, 8'h3c);
        chk({7'h0, accept_ready_n_o}, 8'h01);
        take_rx;
        chk({7'h0, accept_ready_n_o}, 8'h00);
    endtask
    task automatic t_spi; // Master byte out and in, then the slave pin directions
        chk({4'h0, ss_n_oe_o, mosi_oe_o, sclk_oe_o, miso_oe_o}, 8'h0e);
        spi_start_i <= 1'b1;
        @(posedge clock_i);
        spi_start_i <= 1'b0;
        repeat (100) @(posedge clock_i);
        chk(rx_data_o, 8'h5a);
        chk(spi_got, 8'h96);
        take_rx;
        role_master_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk({4'h0, ss_n_oe_o, mosi_oe_o, sclk_oe_o, miso_oe_o}, 8'h01);
    endtask
    task automatic t_status; // Hop lock and remote count always disagree, so a swap shows
        for (int k = 0; k < 4; k++) begin
            is_base_i <= k[1];
            hop_locked_i <= k[0];
            remotes_connected_i <= {3'h0, ~k[0]};
            repeat (3) @(posedge clock_i);
            chk({7'h0, carrier_lock_n_o}, {7'h0, k[0] == k[1]});
        end
    endtask
    task automatic t_gpio;
        gpio_level_i <= 2'h1;
        gpio_write_i <= 2'h3;
        @(posedge clock_i);
        gpio_write_i <= 2'h0;
        repeat (2) @(posedge clock_i);
        chk({6'h0, general_io_five_o, general_io_four_o}, 8'h01);
        gpio_dir_out_i <= 2'h0;
        gpio_pullup_i <= 2'h2;
        repeat (6) @(posedge clock_i);
        chk({6'h0, general_io_five_pullup_o, general_io_four_pullup_o}, 8'h02);
        chk({6'h0, gpio_in_o}, 8'h02);
    endtask
    // ==================================================
    // Main sequence and hang guard
    initial begin
        repeat (8) @(posedge clock_i);
        chk({6'h0, serial_out_o, accept_ready_n_o}, 8'h03);
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk({6'h0, general_io_five_o, general_io_four_o}, 8'h02);
        t_tx();
        t_rx();
        t_spi();
        t_status();
        t_gpio();
        chk({7'h0, activity_flag_o}, 8'h00);
        print_verdict();
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
endmodule
bind radio_host_port host_port_properties #(.REMOTE_W(REMOTE_W)) i_props (.*);

// ---- radio_port_pkg.sv ----
/*
 * Shared constants for the host-facing port of the radio module: serial
 * timing, SPI clock pacing, frame layout and reset levels.
 * Assumes a single 200 MHz core clock and an active-low asynchronous reset.
 */
// Contract
// - Drive host-bound serial data on serial output.
// - Accept host serial data on serial input.
// - Stop sending while permit-send is high; the code still finishes a frame already in flight.
// - Ready low only when input can be accepted.
// - Activity high during transmit or receive.
// - Remote: carrier lock low when hop-synchronized.
// - Base: carrier lock low with remotes connected.
// - Slave select output as master, input as slave.
// - MOSI driven as master, sampled as slave.
// - MISO sampled as master, driven as slave.
// - SPI clock driven as master, received as slave.
// - Inputs four/five offer selectable pull-up.
// - Outputs four/five take configured power-on level.
// - Logic held in reset while reset low.
package radio_port_pkg;

    // ==================================================================
    // Clock and serial timing
    // ==================================================================
    localparam int CLK_HZ = 200_000_000;                 // Core clock rate
    localparam int SERIAL_BAUD = 115_200;                // Default serial rate
    localparam int BIT_CYCLES = CLK_HZ / SERIAL_BAUD;    // Clocks per serial bit
    localparam int SPI_HALF_CYCLES = 10;                 // Clocks per SPI clock half

    // ==================================================================
    // Frame layout
    // ==================================================================
    localparam int DATA_BITS = 8;                        // Bits per character
    localparam logic [3:0] STOP_BIT_INDEX = 4'h9;        // Last bit of a serial frame
    localparam logic [3:0] SPI_LAST_BIT = 4'h7;          // Last bit index of an SPI byte
    localparam logic [3:0] SPI_BYTE_BITS = 4'h8;         // Bits in one SPI byte

    // ==================================================================
    // Reset values
    // ==================================================================
    localparam logic LINE_IDLE = 1'b1;                   // Serial line idles high
    localparam logic READY_N_RESET = 1'b1;               // Not ready while in reset
    localparam logic LOCK_N_RESET = 1'b1;                // No carrier lock at reset
    localparam logic [7:0] SYNC_RESET = 8'hff;           // Synchroniser reset pattern

endpackage

// ---- sync_bits.sv ----
/*
 * Two-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level; multi-bit words are not made coherent.
 */
`timescale 1ns/10ps
module sync_bits #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;       // First stage, read only by the second
    logic [WIDTH-1:0] next_meta;  // Next first stage
    logic [WIDTH-1:0] next_sync;  // Next second stage

    // ==================================================================
    // Next values
    // ==================================================================
    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    // Reset to idle-high so lines look inactive until really sampled
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= WIDTH'(radio_port_pkg::SYNC_RESET);
            sync_o <= WIDTH'(radio_port_pkg::SYNC_RESET);
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end

endmodule
